// ### hdl/ueb_core.sv
// serial port enhancement logic: framing error, break, transmit double buffer
// assumes line input synchronous to clk_i and a wishbone classic master
`timescale 1ns/1ns
// Behaviour
// - framing error shows in status, and in control bit 7 when view is set
// - the receiver flags break after 11 consecutive low bit times
// - a detected break can request a full reset into boot loader mode
// - double buffered, a next character follows after one stop bit
// - status bit 7 enables double buffering; clear is single buffered
// - double buffered, transmit done rises when the holding buffer frees
// - double buffered, the ninth bit is captured at the data write
// - mode 1 frame: start, 8 data lsb first, stop; stop goes to rx ninth
// - modes 2 and 3 frames add a ninth bit before stop; ninth bit is stored
module ueb_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial line
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  // system
  output logic irq_o,
  output logic boot_loader_mode_o
);
  import ueb_pkg::*;

  logic rst_s1, rst_s2;
  logic [7:0] ctrl;
  logic dbl_buffer_enable, brk_rst_en, fe_view_select;
  logic [3:0] mask, sticky;
  logic fe_flag;
  ueb_char_t hold, shreg;
  logic hold_full;
  ueb_state_t tx_state;
  logic [7:0] tx_cnt;
  logic [3:0] tx_bit;
  logic [7:0] rx_data;
  logic rx_busy, shreg_rx9;
  logic [7:0] rx_cnt;
  logic [3:0] rx_bit;
  logic [7:0] brk_cnt;
  logic [3:0] brk_bits;
  logic brk_seen;
  logic wr, rd, wb_hit;
  logic wr_data, wr_ctrl, rd_stat;
  logic tx_end, tx_load, rx_stop, rx_done_ev, tx_done_ev, brk_ev, fe_ev;
  logic [3:0] fr_bits;
  logic [7:0] ctrl_view;
  logic [31:0] next_dat;

  // reset release through two flops
  always_ff @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end

  // bus decode; ack is one cycle and drops after being seen
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = wb_hit && wb_we_i && wb_sel_i[0];
  assign rd = wb_hit && !wb_we_i;
  assign wr_data = wr && wb_adr_i == OFF_DATA;
  assign wr_ctrl = wr && wb_adr_i == OFF_CTRL;
  assign rd_stat = rd && wb_adr_i == OFF_STAT;
  assign fr_bits = ctrl[CTRL_MODE_B0] ? FR_BITS_9 : FR_BITS_8;
  // control bit 7 view follows the select bit
  assign ctrl_view = fe_view_select ? {fe_flag, ctrl[6:0]} : ctrl;

  always_comb
  begin
    next_dat = 32'h0;
    unique case (wb_adr_i)
      OFF_DATA: next_dat = {24'h0, rx_data};
      OFF_CTRL: next_dat = {24'h0, ctrl_view};
      OFF_STAT: next_dat = {24'h0, dbl_buffer_enable, brk_rst_en, mask[1:0],
                            sticky};
      OFF_PWR: next_dat = {24'h0, 1'b0, fe_view_select, 2'h0, mask};
      default: next_dat = 32'h0;
    endcase
  end

  // bus answer registers
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      if (rd)
        wb_dat_o <= next_dat;
    end

  // software configuration; mask written in the power register, its low two bits also read in status
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      dbl_buffer_enable <= 1'b0;
      brk_rst_en <= 1'b0;
      fe_view_select <= 1'b0;
      mask <= MASK_RST;
    end
    else if (wr && wb_adr_i == OFF_STAT)
    begin
      dbl_buffer_enable <= wb_dat_i[STAT_DBL_EN];
      brk_rst_en <= wb_dat_i[STAT_BRK_RST_EN];
    end
    else if (wr && wb_adr_i == OFF_PWR)
    begin
      fe_view_select <= wb_dat_i[PWR_FE_VIEW];
      mask <= wb_dat_i[3:0];
    end

  assign tx_end = tx_state == UEB_SHIFT && tx_cnt == BIT_LAST
                  && tx_bit == fr_bits - 4'h1;
  // load when idle or at a frame end in either mode; the hold stage feeds the next frame
  assign tx_load = hold_full && (tx_state == UEB_IDLE || tx_end);
  // done flag: holding buffer free when double, frame end when single
  assign tx_done_ev = dbl_buffer_enable ? tx_load : tx_end;

  // control register: mode, ninth bits and done flags; set beats clear
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
      ctrl <= CTRL_RST;
    else
    begin
      if (wr_ctrl)
      begin
        if (!(fe_view_select))
          ctrl[7] <= wb_dat_i[7];
        ctrl[6:0] <= wb_dat_i[6:0];
      end
      // ninth bit written while single buffered is read live at shift time
      if (rx_done_ev)
      begin
        ctrl[CTRL_RX_NINTH] <= (fr_bits == FR_BITS_8) ? serial_in_pin_i
                               : shreg_rx9;
        ctrl[CTRL_RX_DONE] <= 1'b1;
      end
      if (tx_done_ev)
        ctrl[CTRL_TX_DONE] <= 1'b1;
    end

  // holding stage, ninth bit captured at the data write
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      hold <= '0;
      hold_full <= 1'b0;
    end
    else if (wr_data)
    begin
      hold.data <= wb_dat_i[7:0];
      hold.ninth <= ctrl[CTRL_TX_NINTH];
      hold_full <= 1'b1;
    end
    else if (tx_load)
      hold_full <= 1'b0;

  // transmit shifter: start, data lsb first, optional ninth, stop
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      tx_state <= UEB_IDLE;
      tx_cnt <= 8'h0;
      tx_bit <= 4'h0;
      shreg <= '0;
      serial_out_pin_o <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_state <= UEB_SHIFT; // back to back after one stop bit
      tx_cnt <= 8'h0;
      tx_bit <= 4'h0;
      shreg <= hold;
      serial_out_pin_o <= 1'b0;
    end
    else
    begin
      unique case (tx_state)
        UEB_IDLE: serial_out_pin_o <= 1'b1;
        UEB_SHIFT:
        begin
          if (tx_cnt == BIT_LAST)
          begin
            tx_cnt <= 8'h0;
            tx_bit <= tx_bit + 4'h1;
            if (tx_end)
              tx_state <= UEB_IDLE;
            else if (tx_bit < 4'h8)
              serial_out_pin_o <= shreg.data[tx_bit[2:0]];
            else if (tx_bit == 4'h8 && fr_bits == FR_BITS_9)
              // single buffered uses the live ninth bit
              serial_out_pin_o <= dbl_buffer_enable ? shreg.ninth
                                  : ctrl[CTRL_TX_NINTH];
            else
              serial_out_pin_o <= 1'b1;
          end
          else
            tx_cnt <= tx_cnt + 8'h1;
        end
        default: tx_state <= UEB_IDLE;
      endcase
    end

  // receiver: start on a falling edge, sample each bit after the start bit mid-bit, stop too
  assign rx_stop = rx_busy && rx_cnt == BIT_HALF && rx_bit == fr_bits - 4'h1;
  assign rx_done_ev = rx_stop;
  assign fe_ev = rx_stop && !serial_in_pin_i;
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      rx_busy <= 1'b0;
      rx_cnt <= 8'h0;
      rx_bit <= 4'h0;
      rx_data <= 8'h0;
      shreg_rx9 <= 1'b0;
    end
    else if (!rx_busy)
    begin
      rx_cnt <= 8'h0;
      rx_bit <= 4'h0;
      // zero low count means the line was high: no restart in a low stop
      if (!serial_in_pin_i && brk_cnt == 8'h0 && brk_bits == 4'h0)
        rx_busy <= 1'b1;
    end
    else
    begin
      rx_cnt <= (rx_cnt == BIT_LAST) ? 8'h0 : rx_cnt + 8'h1;
      if (rx_cnt == BIT_LAST)
        rx_bit <= rx_bit + 4'h1;
      if (rx_cnt == BIT_HALF && rx_bit >= 4'h1 && rx_bit <= 4'h8)
        rx_data <= {serial_in_pin_i, rx_data[7:1]};
      // ninth bit in 9-bit modes only; the mode 1 stop bit goes to rx ninth at rx_stop
      if (rx_cnt == BIT_HALF && rx_bit == 4'h9 && fr_bits == FR_BITS_9)
        shreg_rx9 <= serial_in_pin_i;
      if (rx_stop)
        rx_busy <= 1'b0;
    end

  // break: 11 low bit times, once per low period
  assign brk_ev = !serial_in_pin_i && !brk_seen && brk_bits == BRK_BITS - 4'h1
                  && brk_cnt == BIT_LAST;
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      brk_cnt <= 8'h0;
      brk_bits <= 4'h0;
      brk_seen <= 1'b0;
    end
    else if (serial_in_pin_i)
    begin
      brk_cnt <= 8'h0;
      brk_bits <= 4'h0;
      brk_seen <= 1'b0;
    end
    else if (brk_ev)
      brk_seen <= 1'b1;
    else if (!brk_seen)
    begin
      brk_cnt <= (brk_cnt == BIT_LAST) ? 8'h0 : brk_cnt + 8'h1;
      if (brk_cnt == BIT_LAST)
        brk_bits <= brk_bits + 4'h1;
    end

  // sticky events; a status read clears, a new event in that cycle wins
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      sticky <= 4'h0;
      fe_flag <= 1'b0;
    end
    else
    begin
      sticky <= (rd_stat ? 4'h0 : sticky)
                | {fe_ev, brk_ev, tx_done_ev, rx_done_ev};
      if (fe_ev)
        fe_flag <= 1'b1;
      else if (rd_stat)
        fe_flag <= 1'b0;
    end

  // interrupt and boot loader reset request, both registered
  always_ff @(posedge clk_i or negedge rst_s2)
    if (!rst_s2)
    begin
      irq_o <= 1'b0;
      boot_loader_mode_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(sticky & mask);
      if (brk_ev && brk_rst_en)
        boot_loader_mode_o <= 1'b1;
    end

  a_break_once: assert property (@(posedge clk_i) disable iff (!rst_s2)
    brk_ev |=> !brk_ev [*8]) else $error("break set twice");
  a_break_boot: assert property (@(posedge clk_i) disable iff (!rst_s2)
    brk_ev && brk_rst_en |=> boot_loader_mode_o)
    else $error("break reset missing");
  a_fe_sticky: assert property (@(posedge clk_i) disable iff (!rst_s2)
    fe_ev |=> sticky[STAT_FE]) else $error("framing error lost");
  a_db_done: assert property (@(posedge clk_i) disable iff (!rst_s2)
    dbl_buffer_enable && tx_load |=> ctrl[CTRL_TX_DONE])
    else $error("done not on buffer free");
  a_single_done: assert property (@(posedge clk_i) disable iff (!rst_s2)
    !dbl_buffer_enable && tx_load && !tx_end |=> !sticky[STAT_TXI]
    || $past(sticky[STAT_TXI])) else $error("early done");
  a_start_low: assert property (@(posedge clk_i) disable iff (!rst_s2)
    tx_load |=> !serial_out_pin_o) else $error("no start bit");
  a_ninth_cap: assert property (@(posedge clk_i) disable iff (!rst_s2)
    wr_data |=> hold.ninth == $past(ctrl[CTRL_TX_NINTH]))
    else $error("ninth bit not captured");
  a_fe_view: assert property (@(posedge clk_i) disable iff (!rst_s2)
    rd && wb_adr_i == OFF_CTRL && fe_view_select
    |=> wb_dat_o[7] == $past(fe_flag)) else $error("bad bit 7 view");
endmodule

// ### hdl/ueb_pkg.sv
// package for the serial port enhancement block: register map, fields, timing
// assumes one 125 MHz core clock and a classic wishbone register bus
package ueb_pkg;
  // register byte offsets (one aligned word each)
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_CTRL = 4'h4;
  localparam logic [3:0] OFF_STAT = 4'h8;
  localparam logic [3:0] OFF_PWR = 4'hc;
  // control register fields
  localparam int CTRL_MODE_B0 = 7;
  localparam int CTRL_MODE_B1 = 6;
  localparam int CTRL_TX_NINTH = 3;
  localparam int CTRL_RX_NINTH = 2;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_DONE = 0;
  // status register fields (read clears the sticky bits 3..0)
  localparam int STAT_DBL_EN = 7;
  localparam int STAT_BRK_RST_EN = 6;
  localparam int STAT_MASK_LO = 4;
  localparam int STAT_FE = 3;
  localparam int STAT_BRK = 2;
  localparam int STAT_TXI = 1;
  localparam int STAT_RXI = 0;
  // power control register fields
  localparam int PWR_FE_VIEW = 6;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'h0;
  // bit timing: clocks per bit, a plain default
  localparam int BIT_CLKS = 16;
  localparam logic [7:0] BIT_LAST = 8'(BIT_CLKS - 1);
  localparam logic [7:0] BIT_HALF = 8'(BIT_CLKS / 2);
  localparam logic [3:0] BRK_BITS = 4'hb;
  localparam logic [3:0] FR_BITS_8 = 4'ha;
  localparam logic [3:0] FR_BITS_9 = 4'hb;
  typedef enum logic [1:0] {UEB_IDLE, UEB_SHIFT} ueb_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic ninth;
  } ueb_char_t;
endpackage

// ### testbench/ueb_core_tb_top.sv
// self-checking bench for the serial port enhancement block
// assumes the line partner model and a wishbone classic master in here
`timescale 1ns/1ns
module ueb_core_tb_top;
  import ueb_pkg::*;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd_o;
  logic [31:0] rdat;
  logic ack;
  logic line_in;
  logic line_out;
  logic irq;
  logic boot;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  // 125 MHz core clock
  always #4 clk_i = ~clk_i;

  ueb_core i_ueb_core (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(4'hf),
    .wb_dat_i(wdat),
    .wb_dat_o(rd_o),
    .wb_ack_o(ack),
    .serial_in_pin_i(line_in),
    .serial_out_pin_o(line_out),
    .irq_o(irq),
    .boot_loader_mode_o(boot)
  );

  ueb_line_model i_ueb_line_model (
    .clk_i(clk_i),
    .tx_line_i(line_out),
    .rx_line_o(line_in)
  );

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high, then released
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    rdat = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a);
    wb(1'b0, a, 8'h00);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic wait_frames(input int n);
    while (i_ueb_line_model.frames.size() < n)
      @(posedge clk_i);
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask

  // hang guard: the whole run needs well under 2000 cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 10000)
    begin
      errors++;
      report_and_stop;
    end
  end

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(OFF_CTRL);
    chk(rdat, 32'h0);
    rd(OFF_STAT);
    chk(rdat, 32'h0);
    rd(4'h2);
    chk(rdat, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test reset done");
    // single buffered: done flag waits for the end of the frame
    wr(OFF_DATA, 8'ha5);
    rd(OFF_STAT);
    chk(rdat & 32'h2, 32'h0);
    wait_frames(1);
    chk(32'(i_ueb_line_model.frames[0]), 32'h3a5);
    rd(OFF_STAT);
    chk(rdat & 32'h2, 32'h2);
    $display("test single done");
    // double buffered 9-bit frames; ninth bit changes between writes
    wr(OFF_CTRL, 8'h88);
    wr(OFF_STAT, 8'h80);
    wr(OFF_DATA, 8'h3c);
    rd(OFF_STAT);
    chk(rdat & 32'h82, 32'h82);
    wr(OFF_CTRL, 8'h80);
    wr(OFF_DATA, 8'hc3);
    wait_frames(3);
    chk(32'(i_ueb_line_model.frames[1]), 32'h33c);
    chk(32'(i_ueb_line_model.frames[2]), 32'h2c3);
    chk(32'(i_ueb_line_model.starts[2] - i_ueb_line_model.starts[1]),
      32'(11 * BIT_CLKS));
    $display("test double done");
    // mode 1 receive, then a low stop bit seen through the view select
    wr(OFF_STAT, 8'h00);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_PWR, 8'h48);
    rd(OFF_STAT);
    i_ueb_line_model.send(16'h02b4, 10);
    repeat (BIT_CLKS) @(posedge clk_i);
    rd(OFF_CTRL);
    chk(rdat, 32'h05);
    rd(OFF_DATA);
    chk(rdat, 32'h5a);
    i_ueb_line_model.send(16'h01fe, 10);
    repeat (BIT_CLKS) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_CTRL);
    chk(rdat & 32'h80, 32'h80);
    rd(OFF_STAT);
    chk(rdat & 32'h8, 32'h8);
    repeat (2) @(posedge clk_i);
    chk({31'h0, irq}, 32'h0);
    wr(OFF_PWR, 8'h04);
    rd(OFF_CTRL);
    chk(rdat & 32'h80, 32'h0);
    $display("test framing done");
    // break of 16 low bits: not at 10, flagged by 11, only once
    wr(OFF_STAT, 8'h40);
    rd(OFF_STAT);
    fork
      i_ueb_line_model.send(16'h0000, 16);
    join_none
    repeat (10 * BIT_CLKS) @(posedge clk_i);
    rd(OFF_STAT);
    chk(rdat & 32'h4, 32'h0);
    repeat (2 * BIT_CLKS) @(posedge clk_i);
    chk({31'h0, irq}, 32'h1);
    chk({31'h0, boot}, 32'h1);
    rd(OFF_STAT);
    chk(rdat & 32'h4, 32'h4);
    rd(OFF_STAT);
    chk(rdat & 32'h4, 32'h0);
    repeat (6 * BIT_CLKS) @(posedge clk_i);
    $display("test break done");
    report_and_stop;
  end
endmodule

// ### testbench/ueb_line_model.sv
// remote serial partner: sends frames into the block, records its frames
// assumes the line idles high and a bit lasts BIT_CLKS core clocks
`timescale 1ns/1ns
module ueb_line_model
  import ueb_pkg::*;
(
  // clock
  input wire logic clk_i,
  // serial line
  input wire logic tx_line_i,
  output logic rx_line_o
);
  logic [9:0] frames[$];
  int starts[$];
  int cyc_cnt = 0;
  logic [9:0] bits;

  // cycle count, used to measure start-to-start spacing
  always @(posedge clk_i)
    cyc_cnt <= cyc_cnt + 1;

  // sample ten bits mid-bit after each start edge; the tenth is the stop
  // bit of a 9-bit frame, or idle after a mode 1 frame
  always
  begin
    @(negedge tx_line_i);
    starts.push_back(cyc_cnt);
    repeat (BIT_HALF) @(posedge clk_i);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT_CLKS) @(posedge clk_i);
      bits[i] = tx_line_i;
    end
    frames.push_back(bits);
  end

  // drive n bits lsb first from a clock edge, then return to idle high
  task automatic send(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      rx_line_o <= b[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rx_line_o <= 1'b1;
  endtask

  // line idles high until a frame is sent
  initial
    rx_line_o = 1'b1;
endmodule
